// ---- design/pes_power_enable.sv ----
// design: ignition enable sequencer, strap address, fuse fault monitor
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module pes_power_enable
	import pes_pkg::*;
#(
	parameter int FUSE_N = 8
)(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire pes_ign_t ignPin,
	input wire logic [2:0] strapPin,
	input wire logic [FUSE_N-1:0] fusePowered,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic powerHold,
	output logic recoveryMode,
	output logic highSideDrive,
	output logic [7:0] sourceAddr,
	output logic irq
);
	// register fields are one byte wide, so other widths cannot be served
	if (FUSE_N != 8)
	begin
		$error("FUSE_N must be 8 to fit register fields");
	end

	// two-flop synchronisers for all pin inputs
	pes_ign_t ignMeta, ignSync;
	logic [2:0] strapMeta, strapSync;
	logic [FUSE_N-1:0] fuseMeta, fuseSync;
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			// idle levels, else a false power-up follows reset
			ignMeta <= IGN_IDLE;
			ignSync <= IGN_IDLE;
			strapMeta <= 3'h0;
			strapSync <= 3'h0;
			fuseMeta <= '0;
			fuseSync <= '0;
		end
		else
		begin
			ignMeta <= ignPin;
			ignSync <= ignMeta;
			strapMeta <= strapPin;
			strapSync <= strapMeta;
			fuseMeta <= fusePowered;
			fuseSync <= fuseMeta;
		end
	end

	// comparators against half battery give the Above bits
	logic highActive, lowActive;
	assign highActive = ignSync.ignHighAbove && !ignSync.ignHighOpen;
	assign lowActive = !ignSync.ignLowAbove && !ignSync.ignLowOpen;

	// register state
	logic memBusy, driveCmd;
	logic [7:0] baseAddr, faultDis, population;
	logic [EV_W-1:0] irqStat, irqMask;
	logic [31:0] rdData;
	logic ack;
	logic [31:0] next_rdData;
	logic next_ack;
	logic next_memBusy, next_driveCmd;
	logic [7:0] next_baseAddr, next_faultDis, next_population;
	logic [EV_W-1:0] next_irqStat, next_irqMask;

	pes_state_t state, next_state;
	logic [7:0] next_sourceAddr;
	logic [FUSE_N-1:0] fault, next_fault;
	logic [EV_W-1:0] events;

	function automatic logic [7:0] addr_sum(input logic [7:0] base,
		input logic [2:0] offs);
		addr_sum = base + {5'h00, offs};
	endfunction

	// sequencer
	always_comb
	begin
		next_state = state;
		next_sourceAddr = sourceAddr;
		case (state)
			PES_OFF:
			begin
				if (highActive && lowActive)
					next_state = PES_RECOV;
				else if (highActive || lowActive)
				begin
					next_state = PES_ON;
					next_sourceAddr = addr_sum(baseAddr, strapSync);
				end
			end
			PES_ON:
			begin
				if (highActive && lowActive)
					next_state = PES_RECOV;
				else if (!highActive && !lowActive)
					next_state = PES_WAIT;
			end
			PES_WAIT:
			begin
				if (highActive && lowActive)
					next_state = PES_RECOV;
				else if (highActive || lowActive)
					next_state = PES_ON;
				else if (!memBusy)
					next_state = PES_OFF;
			end
			PES_RECOV:
			begin
				if (!highActive && !lowActive)
					next_state = PES_WAIT;
			end
			default:
				next_state = PES_OFF;
		endcase
	end

	// fault flags only for populated, enabled, running positions
	always_comb
	begin
		next_fault = '0;
		if (state == PES_ON)
			next_fault = ~fuseSync & population & ~faultDis;
	end

	assign events[EV_ON] = (state == PES_OFF) && (next_state == PES_ON);
	assign events[EV_OFF] = (state != PES_OFF) && (next_state == PES_OFF);
	assign events[EV_RECOV] = (state != PES_RECOV) && (next_state == PES_RECOV);
	assign events[EV_FAULT] = |(next_fault & ~fault);

	// bus slave: one wait cycle, answer on the second edge
	always_comb
	begin
		next_ack = 1'b0;
		next_rdData = rdData;
		next_memBusy = memBusy;
		next_driveCmd = driveCmd;
		next_baseAddr = baseAddr;
		next_faultDis = faultDis;
		next_population = population;
		next_irqMask = irqMask;
		next_irqStat = irqStat;
		if ((avs_read || avs_write) && !ack)
		begin
			next_ack = 1'b1;
			if (avs_write)
			begin
				case (avs_address)
					REG_CTRL:
					begin
						next_memBusy = avs_writedata[CTRL_MEM_BUSY];
						next_driveCmd = avs_writedata[CTRL_DRIVE];
						next_baseAddr = avs_writedata[CTRL_BASE_LSB+:8];
						next_faultDis = avs_writedata[CTRL_FDIS_LSB+:8];
						next_population = avs_writedata[CTRL_POP_LSB+:8];
					end
					REG_IRQ_STAT:
						next_irqStat = irqStat & ~avs_writedata[EV_W-1:0];
					REG_IRQ_MASK:
						next_irqMask = avs_writedata[EV_W-1:0];
					default:
						next_ack = 1'b1;
				endcase
			end
			else
			begin
				case (avs_address)
					REG_CTRL:
						next_rdData = {population, faultDis, baseAddr, 6'h00,
							driveCmd, memBusy};
					REG_STATUS:
						next_rdData = {8'h00, sourceAddr, fault, 5'h00,
							highSideDrive, recoveryMode, powerHold};
					REG_IRQ_STAT:
						next_rdData = {28'h0000000, irqStat};
					REG_IRQ_MASK:
						next_rdData = {28'h0000000, irqMask};
					default:
						next_rdData = UNMAPPED_DATA;
				endcase
			end
		end
		// set wins over a same-cycle clear
		next_irqStat = next_irqStat | events;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state <= PES_OFF;
			sourceAddr <= 8'h00;
			fault <= '0;
			ack <= 1'b0;
			rdData <= 32'h0000_0000;
			memBusy <= 1'b0;
			driveCmd <= 1'b0;
			baseAddr <= BASE_RST;
			faultDis <= FDIS_RST;
			population <= POP_RST;
			irqStat <= '0;
			irqMask <= '0;
			powerHold <= 1'b0;
			recoveryMode <= 1'b0;
			highSideDrive <= 1'b0;
			irq <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			state <= next_state;
			sourceAddr <= next_sourceAddr;
			fault <= next_fault;
			ack <= next_ack;
			rdData <= next_rdData;
			memBusy <= next_memBusy;
			driveCmd <= next_driveCmd;
			baseAddr <= next_baseAddr;
			faultDis <= next_faultDis;
			population <= next_population;
			irqStat <= next_irqStat;
			irqMask <= next_irqMask;
			powerHold <= (next_state != PES_OFF);
			recoveryMode <= (next_state == PES_RECOV);
			// drive follows command only while in normal operation
			highSideDrive <= next_driveCmd && (next_state == PES_ON);
			irq <= |(next_irqStat & next_irqMask);
			avs_waitrequest <= !next_ack;
		end
	end

	assign avs_readdata = rdData;

	// assertions
	sequence both_active_s;
		highActive && lowActive;
	endsequence
	sequence all_idle_s;
		!highActive && !lowActive;
	endsequence

	hold_while_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(highActive != lowActive) |=> powerHold)
		else $error("power hold lost with ignition active");
	off_after_mem_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state == PES_WAIT && !memBusy && !highActive && !lowActive
		|=> state == PES_OFF && !powerHold)
		else $error("power off not taken after memory update");
	wait_mem_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state == PES_WAIT && memBusy && !highActive && !lowActive
		|=> state == PES_WAIT)
		else $error("power off did not wait for memory");
	recov_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		both_active_s |=> recoveryMode)
		else $error("recovery mode not entered");
	low_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ignSync.ignLowAbove && !highActive
		|=> state != PES_ON && state != PES_RECOV)
		else $error("low input active above threshold");
	high_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ignSync.ignHighAbove && !lowActive
		|=> state != PES_ON && state != PES_RECOV)
		else $error("high input active below threshold");
	open_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ignSync.ignHighOpen && ignSync.ignLowOpen
		|-> all_idle_s ##1 (state != PES_ON && state != PES_RECOV))
		else $error("open input counted as active");
	addr_latch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		state == PES_OFF ##1 state == PES_ON
		|-> sourceAddr == addr_sum($past(baseAddr), $past(strapSync)))
		else $error("source address not base plus offset");
	fault_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(fault[0]) |-> !$past(faultDis[0]) && $past(population[0]))
		else $error("disabled or empty position reported");
	drive_cmd_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		highSideDrive |-> driveCmd && state == PES_ON)
		else $error("high side drive without command");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		irq == |(irqStat & irqMask))
		else $error("interrupt without cause");
endmodule

// ---- pkg/pes_pkg.sv ----
// package: constants, register map and types of the power enable sequencer
package pes_pkg;
	localparam int ADDR_W = 4;
	// register byte addresses
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hC;
	// control register fields
	localparam int CTRL_MEM_BUSY = 0;
	localparam int CTRL_DRIVE = 1;
	localparam int CTRL_BASE_LSB = 8;
	localparam int CTRL_FDIS_LSB = 16;
	localparam int CTRL_POP_LSB = 24;
	// status register fields
	localparam int ST_HOLD = 0;
	localparam int ST_RECOV = 1;
	localparam int ST_DRIVE = 2;
	localparam int ST_FAULT_LSB = 8;
	localparam int ST_ADDR_LSB = 16;
	// event bits
	localparam int EV_ON = 0;
	localparam int EV_OFF = 1;
	localparam int EV_RECOV = 2;
	localparam int EV_FAULT = 3;
	localparam int EV_W = 4;
	// reset values and unmapped read data
	localparam logic [7:0] BASE_RST = 8'h80;
	localparam logic [7:0] POP_RST = 8'hFF;
	localparam logic [7:0] FDIS_RST = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// state encoding in Gray order OFF, ON, WAIT, RECOV; the power-down step WAIT to OFF flips both bits
	typedef enum logic [1:0] {
		PES_OFF = 2'b00,
		PES_ON = 2'b01,
		PES_WAIT = 2'b11,
		PES_RECOV = 2'b10
	} pes_state_t;
	typedef struct packed {
		logic ignHighAbove;
		logic ignLowAbove;
		logic ignHighOpen;
		logic ignLowOpen;
	} pes_ign_t;
	// idle pin levels: both inputs inactive, none open
	localparam pes_ign_t IGN_IDLE = 4'h4;
endpackage

// ---- sim/pes_harness.sv ----
// harness model: ignition switch wiring and address straps
`timescale 1ns/1ps
module pes_harness
	import pes_pkg::*;
(
	input wire logic clk_sys,
	input wire logic useHigh,
	input wire logic useLow,
	input wire logic openHigh,
	input wire logic openLow,
	input wire logic [2:0] tieMask,
	output pes_ign_t ignPin,
	output logic [2:0] strapPin
);
	// a floating input shows no stable level, so it toggles
	logic flip = 1'h0;
	always_ff @(posedge clk_sys)
	begin
		flip <= !flip;
	end
	always_comb
	begin
		ignPin.ignHighAbove = openHigh ? flip : useHigh;
		ignPin.ignLowAbove = openLow ? !flip : !useLow;
		ignPin.ignHighOpen = openHigh;
		ignPin.ignLowOpen = openLow;
		strapPin = tieMask;
	end
endmodule

// ---- sim/power_enable_address_strap_test.sv ----
// testbench: ignition sequencing, strap address, faults, irq
`timescale 1ns/1ps
module power_enable_address_strap_test
	import pes_pkg::*;
	;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic useHigh = 1'h0, useLow = 1'h0, openHigh = 1'h0, openLow = 1'h0;
	logic [2:0] tieMask = 3'h0;
	logic [7:0] fusePowered = 8'hFF;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'h0, avs_write = 1'h0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, powerHold, recoveryMode, highSideDrive, irq;
	logic [7:0] sourceAddr, base, pop, fdis;
	logic [2:0] strapPin;
	pes_ign_t ignPin;
	int num_errors = 0, num_checks = 0, i;
	pes_harness HARNESS (.clk_sys(clk_sys), .useHigh(useHigh),
		.useLow(useLow), .openHigh(openHigh), .openLow(openLow),
		.tieMask(tieMask), .ignPin(ignPin), .strapPin(strapPin));
	pes_power_enable #(.FUSE_N(8)) DUT (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .ignPin(ignPin), .strapPin(strapPin),
		.fusePowered(fusePowered), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .powerHold(powerHold),
		.recoveryMode(recoveryMode), .highSideDrive(highSideDrive),
		.sourceAddr(sourceAddr), .irq(irq));
	initial
	begin
		forever #12.5 clk_sys = !clk_sys;
	end
	function logic [7:0] addr_exp(input logic [7:0] b, input logic [2:0] t);
		return b + {5'h00, t};
	endfunction
	function logic [7:0] fault_exp(input logic [7:0] p, f, pw);
		return p & ~f & ~pw;
	endfunction
	task report_and_stop;
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'h0)
				break;
		end
		if (n == 20)
		begin
			num_errors++;
			report_and_stop;
		end
		else
		begin
			q = avs_readdata;
			avs_read <= 1'h0;
			avs_write <= 1'h0;
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask
	task rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, '0, q);
		check(q, e);
	endtask
	// status is polled since the pin path has a few sync stages
	task poll(input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		for (int k = 0; k < 40; k++)
		begin
			bus(1'h0, REG_STATUS, '0, q);
			if ((q & m) === e)
				break;
		end
		check(q & m, e);
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		num_errors++;
		report_and_stop;
	end
	initial
	begin
		void'($urandom(49019));
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rdc(REG_CTRL, {POP_RST, FDIS_RST, BASE_RST, 8'h00});
		rdc(REG_STATUS, 32'h0000_0000);
		wr(4'h2, 32'hFFFF_FFFF);
		rdc(4'h2, UNMAPPED_DATA);
		rdc(REG_CTRL, {POP_RST, FDIS_RST, BASE_RST, 8'h00});
		wr(REG_IRQ_MASK, 32'h0000_000F);
		for (i = 0; i < 4; i++)
		begin
			base = (i == 0) ? 8'hFF : 8'($urandom);
			pop = (i == 0) ? 8'hFF : 8'($urandom);
			fdis = (i == 0) ? 8'h00 : 8'($urandom);
			tieMask <= (i == 0) ? 3'h7 : 3'($urandom);
			fusePowered <= (i == 0) ? 8'h00 : 8'($urandom);
			wr(REG_CTRL, {pop, fdis, base, 8'h00});
			if (i[0])
				useLow <= 1'h1;
			else
				useHigh <= 1'h1;
			poll(32'h0000_0001, 32'h0000_0001);
			check(powerHold, 1'h1);
			check(sourceAddr, addr_exp(base, tieMask));
			poll(32'h0000_FF00, {16'h0000,
				fault_exp(pop, fdis, fusePowered), 8'h00});
			poll(32'h0000_0004, 32'h0000_0000);
			wr(REG_CTRL, {pop, fdis, base, 8'h03});
			poll(32'h0000_0004, 32'h0000_0004);
			check(highSideDrive, 1'h1);
			if (i >= 2)
			begin
				openHigh <= !i[0];
				openLow <= i[0];
			end
			else
			begin
				useHigh <= 1'h0;
				useLow <= 1'h0;
			end
			repeat (20) @(posedge clk_sys);
			check(powerHold, 1'h1);
			wr(REG_CTRL, {pop, fdis, base, 8'h00});
			poll(32'h0000_0001, 32'h0000_0000);
			check(irq, 1'h1);
			wr(REG_IRQ_MASK, 32'h0000_0000);
			repeat (3) @(posedge clk_sys);
			check(irq, 1'h0);
			rdc(REG_IRQ_STAT, {28'h0000000,
				|fault_exp(pop, fdis, fusePowered), 3'h3});
			wr(REG_IRQ_STAT, 32'h0000_000F);
			rdc(REG_IRQ_STAT, 32'h0000_0000);
			wr(REG_IRQ_MASK, 32'h0000_000F);
			useHigh <= 1'h0;
			useLow <= 1'h0;
			openHigh <= 1'h0;
			openLow <= 1'h0;
		end
		useHigh <= 1'h1;
		useLow <= 1'h1;
		poll(32'h0000_0006, 32'h0000_0002);
		check(recoveryMode, 1'h1);
		useHigh <= 1'h0;
		useLow <= 1'h0;
		poll(32'h0000_0003, 32'h0000_0000);
		report_and_stop;
	end
endmodule
